// file: core/flash_ctrl_map.svh
// register offsets, reset values and fixed codes of the flash control registers
`ifndef FLASH_CTRL_MAP_SVH
`define FLASH_CTRL_MAP_SVH
`define ACC_OFS 8'h00
`define FLAG_OFS 8'h04
`define WAIT_OFS 8'h08
`define TRIM_OFS 8'h0C
`define SEC_OFS 8'h10
`define ACC_RST 2'h2
`define ACC_PROG 2'h1
`define WAIT_RST 3'h0
`define TRIM_RST 10'h000
`define HANG_BIT 1
`define RDY_BIT 0
`define SEC_ADDR 32'h0010_0000
`define TRIM_ADDR 32'h0010_0004
`define SEC_CODE 16'h0001
`define ERASED_WORD 32'hFFFF_FFFF
`define MODE_USER 2'h0
`define MODE_SERIAL 2'h1
`endif

// file: core/flash_ctrl_pkg.sv
// types shared by the flash control register block
package flash_ctrl_pkg;
	typedef enum logic [2:0] {LD_SEC_REQ, LD_SEC_WAIT, LD_TRIM_REQ, LD_TRIM_WAIT, LD_DONE} load_state_t;
	typedef struct packed {
		logic busy;
		logic hang;
	} flash_stat_t;
	typedef struct packed {
		logic valid;
		logic chipErase;
		logic infoErase;
	} flash_cmd_t;
	typedef struct packed {
		logic req;
		logic [31:0] addr;
	} load_req_t;
	typedef struct packed {
		logic valid;
		logic [31:0] data;
	} load_rsp_t;
endpackage

// file: core/pin_sync.sv
// two-flop synchroniser for the boot mode pins
`timescale 1ns/10ps
module pin_sync (
	input wire logic clk, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic [1:0] pinIn, // raw pin levels
	output logic [1:0] pinOut // synchronised levels
);
	logic [1:0] meta_q;
	logic [1:0] sync_q;

	// first stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= 2'h0;
			sync_q <= 2'h0;
		end else begin
			meta_q <= pinIn;
			sync_q <= meta_q;
		end
	end

	assign pinOut = sync_q;
endmodule

// file: core/flash_ctrl_security_regs.sv
// flash control/status registers with read protection, reached over apb
//
// Overview of operation
// - access size resets to 10, selecting 32-bit execute-only flash reads
// - access size 01 selects half-word programming; 00 and 11 never written
// - hang flag at status bit 1 shows the timing-limit hang state
// - status bit 0 reads 0 while program or erase runs, 1 when done
// - status bits 7 to 2 are reserved, writes to them ignored
// - wait field adds 0,1,3,5,7 read waits; other codes unused; resets 0
// - after reset trim copy loads low ten bits of flash word 0x0010_0004
// - trim copy reads zero after a chip reset following a flash erase
// - flash is protected when word 0x0010_0000 holds 0x0001
// - protection takes effect only at a later reset, not when written
// - protection is removed only by a reset after a completed chip erase
// - protected in user mode: commands and reads normal, debug blocked
// - protected in serial mode: only chip erase, reads invalid, debug blocked
// - security code and trim word are always erased together
`timescale 1ns/10ps
`include "flash_ctrl_map.svh"
module flash_ctrl_security_regs (
	input wire logic clk, // system clock, 25 MHz
	input wire logic rst_n, // synchronous reset, active low
	input wire logic [7:0] paddr, // apb byte address
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction, high for write
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire flash_ctrl_pkg::flash_stat_t flashStat, // busy and hang from flash sequencer
	input wire flash_ctrl_pkg::flash_cmd_t cmdIn, // decoded flash command
	output flash_ctrl_pkg::load_req_t loadReq, // post-reset word fetch request
	input wire flash_ctrl_pkg::load_rsp_t loadRsp, // fetched word
	input wire logic [1:0] bootModePins, // mode pins, asynchronous
	output logic [1:0] accessWidthSel, // access size to the array
	output logic [2:0] waitCount, // read wait cycles in execute mode
	output logic cmdAccept, // command passed to the sequencer
	output logic cmdReject, // command refused
	output logic readInvalid, // array reads return invalid data
	output logic dbgBlock, // debug port access blocked
	output logic infoEraseBoth // erase security code and trim word together
);
	import flash_ctrl_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// mode pin synchroniser

	logic [1:0] modeSync;

	pin_sync u_mode_sync (
		.clk(clk),
		.rst_n(rst_n),
		.pinIn(bootModePins),
		.pinOut(modeSync)
	);

	////////////////////////////////////////////////////////////////////////////////
	// decode helpers

	function automatic logic regHit(input logic [7:0] a);
		regHit = (a == `ACC_OFS) || (a == `FLAG_OFS) || (a == `WAIT_OFS) ||
			(a == `TRIM_OFS) || (a == `SEC_OFS);
	endfunction

	function automatic logic waitLegal(input logic [2:0] w);
		waitLegal = (w == 3'h0) || w[0];
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// post-reset fetch of security code and trim word

	load_state_t ldState_q, ldState_d;
	load_req_t load_q, load_d;
	logic prot_q, prot_d;
	logic [9:0] trim_q, trim_d;

	// protection is only ever decided here, so a write to the code word waits for a reset
	always_comb begin
		ldState_d = ldState_q;
		load_d = load_q;
		prot_d = prot_q;
		trim_d = trim_q;
		case (ldState_q)
			LD_SEC_REQ: begin
				load_d.req = 1'b1;
				load_d.addr = `SEC_ADDR;
				ldState_d = LD_SEC_WAIT;
			end
			LD_SEC_WAIT: begin
				if (loadRsp.valid) begin
					// latched only in the fetch after reset
					prot_d = (loadRsp.data[15:0] == `SEC_CODE);
					load_d.req = 1'b0;
					ldState_d = LD_TRIM_REQ;
				end
			end
			LD_TRIM_REQ: begin
				load_d.req = 1'b1;
				load_d.addr = `TRIM_ADDR;
				ldState_d = LD_TRIM_WAIT;
			end
			LD_TRIM_WAIT: begin
				if (loadRsp.valid) begin
					// erased word leaves the copy cleared
					trim_d = (loadRsp.data == `ERASED_WORD) ? `TRIM_RST : loadRsp.data[9:0];
					load_d.req = 1'b0;
					ldState_d = LD_DONE;
				end
			end
			LD_DONE: begin
				// chip erase during run does not unlock until next reset
				ldState_d = LD_DONE;
			end
			default: begin
				ldState_d = LD_SEC_REQ;
			end
		endcase
	end

	// fetch state registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ldState_q <= LD_SEC_REQ;
			load_q <= '0;
			prot_q <= 1'b0;
			trim_q <= `TRIM_RST;
		end else begin
			ldState_q <= ldState_d;
			load_q <= load_d;
			prot_q <= prot_d;
			trim_q <= trim_d;
		end
	end

	assign loadReq = load_q;

	////////////////////////////////////////////////////////////////////////////////
	// apb slave and control registers

	logic [1:0] acc_q, acc_d;
	logic [2:0] wait_q, wait_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic rdPhase, wrTake;
	logic [31:0] rdMux;

	// ready one cycle into the access phase keeps the read mux off the bus path
	assign rdPhase = psel && penable && !pready_q;
	assign wrTake = psel && penable && pready_q && pwrite;

	// read mux; reserved bits read zero
	always_comb begin
		rdMux = 32'h0000_0000;
		case (paddr)
			`ACC_OFS: rdMux[1:0] = acc_q;
			`FLAG_OFS: begin
				rdMux[`HANG_BIT] = flashStat.hang;
				// ready flag is inverse of busy
				rdMux[`RDY_BIT] = !flashStat.busy;
			end
			`WAIT_OFS: rdMux[2:0] = wait_q;
			`TRIM_OFS: rdMux[9:0] = trim_q;
			`SEC_OFS: rdMux[4:0] = {modeSync, (ldState_q == LD_DONE), 1'b0, prot_q};
			default: rdMux = 32'h0000_0000;
		endcase
	end

	// next values of bus answer and control fields
	always_comb begin
		acc_d = acc_q;
		wait_d = wait_q;
		pready_d = rdPhase;
		pslverr_d = rdPhase && !regHit(paddr);
		prdata_d = (rdPhase && !pwrite) ? rdMux : 32'h0000_0000;
		if (wrTake) begin
			// prohibited encodings are dropped, old mode kept
			if (paddr == `ACC_OFS && (pwdata[1:0] == `ACC_PROG || pwdata[1:0] == `ACC_RST)) begin
				acc_d = pwdata[1:0];
			end
			// only the documented wait codes are stored
			if (paddr == `WAIT_OFS && waitLegal(pwdata[2:0])) begin
				wait_d = pwdata[2:0];
			end
		end
	end

	// bus and control registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			acc_q <= `ACC_RST;
			wait_q <= `WAIT_RST;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			wait_q <= wait_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign accessWidthSel = acc_q;
	assign waitCount = wait_q;

	////////////////////////////////////////////////////////////////////////////////
	// protection gating of commands, reads and debug

	logic serialLock;
	logic cmdOk;
	logic cmdAccept_q, cmdAccept_d;
	logic cmdReject_q, cmdReject_d;
	logic readInvalid_q, readInvalid_d;
	logic dbgBlock_q, dbgBlock_d;
	logic infoErase_q, infoErase_d;

	assign serialLock = prot_q && (modeSync == `MODE_SERIAL);
	assign cmdOk = !serialLock || cmdIn.chipErase;

	// debug stays blocked until the code word is known, so no window opens at boot
	always_comb begin
		// user mode passes commands, debug blocked when protected
		// protected serial mode keeps only chip erase and spoils reads
		cmdAccept_d = cmdIn.valid && cmdOk;
		cmdReject_d = cmdIn.valid && !cmdOk;
		readInvalid_d = serialLock;
		dbgBlock_d = prot_q || (ldState_q != LD_DONE);
		// either info word erase takes both words
		infoErase_d = cmdIn.valid && cmdOk && (cmdIn.infoErase || cmdIn.chipErase);
	end

	// gating registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cmdAccept_q <= 1'b0;
			cmdReject_q <= 1'b0;
			readInvalid_q <= 1'b0;
			dbgBlock_q <= 1'b1;
			infoErase_q <= 1'b0;
		end else begin
			cmdAccept_q <= cmdAccept_d;
			cmdReject_q <= cmdReject_d;
			readInvalid_q <= readInvalid_d;
			dbgBlock_q <= dbgBlock_d;
			infoErase_q <= infoErase_d;
		end
	end

	assign cmdAccept = cmdAccept_q;
	assign cmdReject = cmdReject_q;
	assign readInvalid = readInvalid_q;
	assign dbgBlock = dbgBlock_q;
	assign infoEraseBoth = infoErase_q;

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	acc_reset_a: assert property ($rose(rst_n) |-> accessWidthSel == `ACC_RST)
		else $error("access size not execute mode after reset");
	acc_legal_a: assert property (accessWidthSel == `ACC_PROG || accessWidthSel == `ACC_RST)
		else $error("access size holds a prohibited code");
	wait_legal_a: assert property (waitLegal(waitCount))
		else $error("wait field holds a prohibited code");
	hang_read_a: assert property (rdPhase && !pwrite && paddr == `FLAG_OFS
		|=> prdata[`HANG_BIT] == $past(flashStat.hang) && pready)
		else $error("hang flag read wrong");
	rdy_read_a: assert property (rdPhase && !pwrite && paddr == `FLAG_OFS
		|=> prdata[`RDY_BIT] == !$past(flashStat.busy))
		else $error("ready flag read wrong");
	resv_zero_a: assert property (rdPhase && !pwrite && paddr == `FLAG_OFS
		|=> prdata[31:2] == 30'h0000_0000)
		else $error("reserved status bits not zero");
	prot_code_a: assert property (ldState_q == LD_SEC_WAIT && loadRsp.valid
		|=> prot_q == ($past(loadRsp.data[15:0]) == `SEC_CODE))
		else $error("protection not taken from code word");
	prot_stable_a: assert property (ldState_q == LD_DONE |=> $stable(prot_q))
		else $error("protection changed outside reset");
	trim_load_a: assert property (ldState_q == LD_TRIM_WAIT && loadRsp.valid
		&& loadRsp.data != `ERASED_WORD |=> trim_q == $past(loadRsp.data[9:0]))
		else $error("trim copy not loaded");
	trim_clear_a: assert property (ldState_q == LD_TRIM_WAIT && loadRsp.valid
		&& loadRsp.data == `ERASED_WORD |=> trim_q == `TRIM_RST ##1 trim_q == `TRIM_RST)
		else $error("trim copy not cleared after erase");
	user_mode_a: assert property (prot_q && modeSync == `MODE_USER && cmdIn.valid
		|=> cmdAccept && dbgBlock && !readInvalid)
		else $error("user mode gating wrong");
	serial_mode_a: assert property (serialLock && cmdIn.valid && !cmdIn.chipErase
		|=> cmdReject && !cmdAccept && readInvalid && dbgBlock)
		else $error("serial mode gating wrong");
	info_erase_a: assert property (cmdIn.valid && cmdIn.infoErase && cmdOk
		|=> infoEraseBoth)
		else $error("info words not erased together");

	prog_mode_c: cover property (wrTake && paddr == `ACC_OFS && pwdata[1:0] == `ACC_PROG);
	protected_c: cover property (ldState_q == LD_DONE && prot_q);
	serial_erase_c: cover property (serialLock && cmdIn.valid && cmdIn.chipErase);
	unmapped_c: cover property (pslverr);
endmodule

// file: bench/tb_top.sv
// self-checking bench for the flash control register block
`timescale 1ns/10ps
`include "flash_ctrl_map.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin errors++; \
	$display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_top;
	import flash_ctrl_pkg::*;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, secWord, trimWord;
	flash_stat_t flashStat;
	flash_cmd_t cmdIn;
	load_req_t loadReq;
	load_rsp_t loadRsp;
	logic [1:0] bootModePins, accessWidthSel, st;
	logic [2:0] waitCount, cmdExp, w;
	logic cmdAccept, cmdReject, readInvalid, dbgBlock, infoEraseBoth;
	logic [32:0] rdQ[$];
	logic [2:0] cmdQ[$];
	logic [32:0] rdExp;
	int errors, checks, rspCnt, rspSeen;

	flash_ctrl_security_regs DUT (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .flashStat(flashStat), .cmdIn(cmdIn),
		.loadReq(loadReq), .loadRsp(loadRsp), .bootModePins(bootModePins),
		.accessWidthSel(accessWidthSel), .waitCount(waitCount), .cmdAccept(cmdAccept),
		.cmdReject(cmdReject), .readInvalid(readInvalid), .dbgBlock(dbgBlock),
		.infoEraseBoth(infoEraseBoth));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////
	// flash fetch side: answers after a few cycles, data wanders while idle
	// each signal gets one assignment per edge, so the answer cannot be overwritten
	always @(posedge clk) begin
		if (rst_n && rspCnt == 3) begin
			loadRsp.valid <= 1'b1;
			loadRsp.data <= (loadReq.addr === `SEC_ADDR) ? secWord : trimWord;
			rspCnt <= 0;
			rspSeen <= rspSeen + 1;
		end else begin
			loadRsp.valid <= 1'b0;
			loadRsp.data <= ~loadRsp.data;
			rspCnt <= (loadReq.req === 1'b1 && !loadRsp.valid) ? rspCnt + 1 : 0;
			rspSeen <= rst_n ? rspSeen : 0;
		end
	end

	// monitor: every answer is matched against the oldest note
	always @(posedge clk) begin
		if (pready === 1'b1) begin
			rdExp = rdQ.pop_front();
			`CHK("apb answer", rdExp, {pslverr, prdata})
		end
		if (cmdAccept === 1'b1 || cmdReject === 1'b1) begin
			cmdExp = cmdQ.pop_front();
			`CHK("command answer", cmdExp, {cmdAccept, cmdReject, infoEraseBoth})
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// one apb transfer; request held until pready is seen at an edge
	// no cycle count is assumed here: only the watchdog ends a hung wait
	task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d,
		input logic [32:0] ex);
		rdQ.push_back(ex);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d, 33'h0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ex);
		apb(a, 1'b0, $urandom, {1'b0, ex});
	endtask

	// command pulse; the answer is checked by the monitor
	task automatic cmd(input logic ce, input logic ie, input logic [2:0] ex);
		cmdQ.push_back(ex);
		@(posedge clk);
		cmdIn <= '{1'b1, ce, ie};
		@(posedge clk);
		cmdIn <= '0;
		repeat (2) @(posedge clk);
	endtask

	// reset with the given mode pins, then wait for both fetches to land
	task automatic reset(input logic [1:0] mode);
		int n;
		bootModePins <= mode;
		rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		for (n = 0; n < 60 && rspSeen < 2; n++) begin
			@(posedge clk);
		end
		repeat (2) @(posedge clk);
	endtask

	task automatic conclude();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// watchdog: the sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		conclude();
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(26));
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		rspCnt = 0;
		rspSeen = 0;
		errors = 0;
		checks = 0;
		flashStat = '0;
		cmdIn = '0;
		loadRsp = '0;
		bootModePins = 2'h0;
		secWord = 32'h0;
		trimWord = $urandom;
		reset(`MODE_USER);
		rd(`ACC_OFS, 32'h2);
		rd(`WAIT_OFS, 32'h0);
		rd(`TRIM_OFS, {22'h0, trimWord[9:0]});
		rd(`SEC_OFS, 32'h4);
		// no array writes in programming mode
		wr(`ACC_OFS, 32'h1);
		rd(`ACC_OFS, 32'h1);
		`CHK("access size", 2'h1, accessWidthSel)
		wr(`ACC_OFS, 32'h0);
		rd(`ACC_OFS, 32'h1);
		wr(`ACC_OFS, 32'h3);
		rd(`ACC_OFS, 32'h1);
		wr(`ACC_OFS, 32'h2);
		rd(`ACC_OFS, 32'h2);
		w = 3'h0;
		// every wait code; prohibited ones keep the old value
		for (int i = 0; i < 8; i++) begin
			wr(`WAIT_OFS, {29'($urandom), i[2:0]});
			w = (i[0] || i == 0) ? i[2:0] : w;
			rd(`WAIT_OFS, {29'h0, w});
			`CHK("wait count", w, waitCount)
		end
		// no command precedes these reads
		// live busy and hang levels; writes to the flags are ignored
		for (int i = 0; i < 6; i++) begin
			st = 2'(i ^ $urandom);
			flashStat <= st;
			wr(`FLAG_OFS, 32'hFFFF_FFFF);
			rd(`FLAG_OFS, {30'h0, st[0], ~st[1]});
		end
		wr(`TRIM_OFS, ~trimWord);
		rd(`TRIM_OFS, {22'h0, trimWord[9:0]});
		apb(8'h14, 1'b1, 32'h1, {1'b1, 32'h0});
		cmd(1'b0, 1'b0, 3'b100);
		cmd(1'b0, 1'b1, 3'b101);
		secWord = 32'h0000_0001;
		cmd(1'b0, 1'b0, 3'b100);
		rd(`SEC_OFS, 32'h4);
		reset(`MODE_SERIAL);
		rd(`SEC_OFS, 32'hD);
		`CHK("invalid reads", 1'b1, readInvalid)
		`CHK("debug block", 1'b1, dbgBlock)
		cmd(1'b0, 1'b0, 3'b010);
		cmd(1'b0, 1'b1, 3'b010);
		cmd(1'b1, 1'b0, 3'b101);
		rd(`SEC_OFS, 32'hD);
		reset(`MODE_USER);
		rd(`SEC_OFS, 32'h5);
		`CHK("invalid reads", 1'b0, readInvalid)
		`CHK("debug block", 1'b1, dbgBlock)
		cmd(1'b0, 1'b0, 3'b100);
		secWord = `ERASED_WORD;
		trimWord = `ERASED_WORD;
		reset(`MODE_USER);
		rd(`SEC_OFS, 32'h4);
		rd(`TRIM_OFS, 32'h0);
		`CHK("debug block", 1'b0, dbgBlock)
		repeat (4) @(posedge clk);
		`CHK("open notes", 0, rdQ.size() + cmdQ.size())
		conclude();
	end
endmodule
